// File: rtl/atc_ctrl.sv
// acquisition sequencer and trigger unit with avalon register slave
`timescale 1ns/1ps
`include "atc_params.svh"
module atc_ctrl
	import atc_pkg::*;
#(
	parameter logic [31:0] AUTO_TMO_RST = `ATC_ATO_CYC,
	parameter logic signed [15:0] LVL_MIN = `ATC_LVL_MIN_DEF
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// avalon-mm slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// signal and trigger inputs
	input wire logic sample_valid,
	input wire logic signed [15:0] sample_level,
	input wire logic ext_trig_in,
	input wire logic [7:0] chan_trig_in,
	input wire logic [2:0] own_chan,
	input wire logic acq_done,
	// capture engine control
	output logic acq_start,
	output logic acq_active,
	output logic trace_clear,
	output logic trig_out,
	output logic slave_mode,
	output logic [4:0] timebase_idx,
	output logic signed [31:0] trig_delay_ns,
	output logic signed [7:0] trig_pos_div,
	output logic [3:0] rate_shift
);

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------

	// timebase index to ns per division, 1-2-5 from 5 ns
	function automatic logic [39:0] tb_ns(input logic [4:0] idx);
		logic [5:0] j;
		logic [39:0] v;
		j = {1'b0, idx} + 6'h02;
		v = (j % 6'h03 == 6'h00) ? 40'd1 : (j % 6'h03 == 6'h01) ? 40'd2 : 40'd5;
		for (int k = 0; k < 8; k++)
		begin
			if (6'(k) < j / 6'h03)
			begin
				v = v * 40'd10;
			end
		end
		return v;
	endfunction

	// limits row for a timebase; rows widen toward slow scales
	function automatic logic [3:0] tb_row(input logic [4:0] idx);
		if (idx <= 5'h0a)
			return 4'h0;
		else if (idx <= 5'h10)
			return 4'(idx - 5'h0a);
		else if (idx <= 5'h13)
			return 4'h7;
		else
			return 4'(idx - 5'h0c);
	endfunction

	// clamp a requested delay into the range of the timebase
	function automatic logic signed [31:0] dly_clamp(input logic signed [31:0] d,
		input logic [4:0] idx);
		logic [31:0] mn;
		logic [31:0] mx;
		case (tb_row(idx))
			4'h0: mn = `ATC_DMIN0;
			4'h1: mn = `ATC_DMIN0;
			4'h2: mn = `ATC_DMIN2;
			4'h3: mn = `ATC_DMIN3;
			4'h4: mn = `ATC_DMIN4;
			4'h5: mn = `ATC_DMIN5;
			4'h6: mn = `ATC_DMIN6;
			4'h7: mn = `ATC_DMIN7;
			4'h8: mn = `ATC_DMIN8;
			default: mn = `ATC_DMIN9;
		endcase
		case (tb_row(idx))
			4'h0: mx = `ATC_DMAX0;
			4'h1: mx = `ATC_DMAX1;
			4'h2: mx = `ATC_DMAX1;
			4'h3: mx = `ATC_DMAX3;
			default: mx = `ATC_DMAX4;
		endcase
		if (d < -$signed(mn))
			return -$signed(mn);
		else if (d > $signed(mx))
			return $signed(mx);
		else
			return d;
	endfunction

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;
	wire bus_req = avs_read | avs_write;
	wire wr_go = avs_write & ack_q;
	wire [31:0] wd = avs_writedata;
	wire wr_cmd = wr_go && avs_address == `ATC_REG_CMD;

	// every access waits exactly one cycle, data is latched before the ack
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			ack_q <= 1'b0;
		else
			ack_q <= bus_req & ~ack_q;
	end
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			rdata_q <= 32'h00000000;
		else if (bus_req & ~ack_q)
			rdata_q <= rd_mux;
	end
	assign avs_waitrequest = bus_req & ~ack_q;
	assign avs_readdata = rdata_q;

	// command pulses
	wire c_run = wr_cmd & wd[`ATC_CMD_RUN];
	wire c_halt = wr_cmd & wd[`ATC_CMD_HALT];
	wire c_single = wr_cmd & wd[`ATC_CMD_SINGLE];
	wire c_clear = wr_cmd & wd[`ATC_CMD_CLEAR];
	wire c_dflt = wr_cmd & wd[`ATC_CMD_DFLT];
	wire c_zero = wr_cmd & wd[`ATC_CMD_ZERO];
	wire c_posl = wr_cmd & wd[`ATC_CMD_POSL];
	wire c_posm = wr_cmd & wd[`ATC_CMD_POSM];
	wire c_posr = wr_cmd & wd[`ATC_CMD_POSR];
	wire set_rst = sys_rst | c_dflt;

	// ------------------------------------------------------------
	// settings registers
	// ------------------------------------------------------------
	logic [4:0] tb_q;
	logic signed [31:0] dly_q;
	logic signed [7:0] pos_q;
	logic [8:0] tctl_q;
	logic signed [15:0] lvl_q;
	logic signed [15:0] ofs_q;
	logic [31:0] hold_q;
	logic [31:0] ato_q;

	wire wr_tb = wr_go && avs_address == `ATC_REG_TB;
	wire wr_dly = wr_go && avs_address == `ATC_REG_DLY;
	wire wr_pos = wr_go && avs_address == `ATC_REG_POS;
	wire wr_tctl = wr_go && avs_address == `ATC_REG_TCTL;
	wire wr_lvl = wr_go && avs_address == `ATC_REG_LVL;
	wire wr_ofs = wr_go && avs_address == `ATC_REG_OFS;
	wire wr_hold = wr_go && avs_address == `ATC_REG_HOLD;
	wire wr_ato = wr_go && avs_address == `ATC_REG_ATO;

	// requested values pinned to their legal ranges
	wire [4:0] tb_req = (wd[4:0] > `ATC_TB_MAX) ? `ATC_TB_MAX : wd[4:0];
	wire signed [7:0] pos_w = $signed(wd[7:0]);
	wire signed [7:0] pos_req = (pos_w < `ATC_POS_MIN) ? `ATC_POS_MIN :
		(pos_w > `ATC_POS_MAX) ? `ATC_POS_MAX : pos_w;
	// software sees level with offset added, so subtract it before storing
	wire signed [16:0] lvl_raw = 17'($signed(wd[15:0])) - 17'(ofs_q);
	wire signed [15:0] lvl_req = (lvl_raw > 17'(`ATC_LVL_MAX)) ? `ATC_LVL_MAX :
		(lvl_raw < 17'(LVL_MIN)) ? LVL_MIN : lvl_raw[15:0];
	wire signed [31:0] dly_src = c_zero ? 32'sh00000000 : wr_dly ? $signed(wd) : dly_q;

	always_ff @(posedge core_clk)
	begin
		if (set_rst)
			tb_q <= `ATC_TB_RST;
		else if (wr_tb)
			tb_q <= tb_req;
	end
	// delay is re-clamped every cycle so a timebase change narrows it too
	always_ff @(posedge core_clk)
	begin
		if (set_rst)
			dly_q <= 32'sh00000000;
		else
			dly_q <= dly_clamp(dly_src, tb_q);
	end
	always_ff @(posedge core_clk)
	begin
		if (set_rst)
			pos_q <= `ATC_POS_RST;
		else if (c_posl)
			pos_q <= `ATC_POS_RST;
		else if (c_posm)
			pos_q <= `ATC_POS_MID;
		else if (c_posr)
			pos_q <= `ATC_POS_RIGHT;
		else if (wr_pos)
			pos_q <= pos_req;
	end
	always_ff @(posedge core_clk)
	begin
		if (set_rst)
		begin
			tctl_q <= `ATC_TCTL_RST;
			lvl_q <= `ATC_LVL_RST;
			ofs_q <= 16'sh0000;
			hold_q <= `ATC_HOLD_RST;
			ato_q <= AUTO_TMO_RST;
		end
		else
		begin
			if (wr_tctl)
				tctl_q <= wd[8:0];
			if (wr_lvl)
				lvl_q <= lvl_req;
			if (wr_ofs)
				ofs_q <= wd[15:0];
			if (wr_hold)
				hold_q <= wd;
			if (wr_ato)
				ato_q <= wd;
		end
	end

	// control fields
	wire [1:0] mode = tctl_q[`ATC_TC_MODE +: 2];
	wire slope_neg = tctl_q[`ATC_TC_SLOPE];
	wire gap_mode = tctl_q[`ATC_TC_HMODE];
	wire [1:0] src = tctl_q[`ATC_TC_SRC +: 2];
	wire [2:0] chsel = tctl_q[`ATC_TC_CHSEL +: 3];

	// ------------------------------------------------------------
	// sample rate reduction
	// ------------------------------------------------------------
	// pre-trigger span = position * div time - delay; positive delay shortens it
	wire signed [39:0] pre_ns = 40'($signed(pos_q)) * $signed(tb_ns(tb_q)) - 40'(dly_q);
	logic [3:0] shift_c;
	always_comb
	begin
		shift_c = 4'h0;
		for (int k = 0; k < 15; k++)
		begin
			if (pre_ns > (`ATC_PRE_MAX_NS <<< k))
				shift_c = 4'(k + 1);
		end
	end

	// ------------------------------------------------------------
	// trigger source and edge detection
	// ------------------------------------------------------------
	logic signed [15:0] pk_max_q;
	logic signed [15:0] pk_min_q;
	logic signed [15:0] al_thr_q;
	logic [7:0] win_q;
	logic above_q;
	logic ext_q;
	logic armed_q;
	logic [31:0] ho_cnt_q;
	logic [31:0] to_cnt_q;

	wire self_src = src == SRC_OWN || (src == SRC_CHAN && chsel == own_chan);
	wire slave = src == SRC_CHAN && chsel != own_chan;
	wire signed [15:0] thr = (mode == TM_AUTOLVL) ? al_thr_q : lvl_q;
	wire above_now = sample_level >= thr;
	// a crossing of the chosen slope only, on a fresh sample
	wire lvl_edge = sample_valid & (slope_neg ? (above_q & ~above_now) : (~above_q & above_now));
	wire ext_edge = slope_neg ? (ext_q & ~ext_trig_in) : (~ext_q & ext_trig_in);
	wire raw_edge = self_src ? lvl_edge : slave ? chan_trig_in[chsel] :
		(src == SRC_EXT) & ext_edge;
	// inactive side of the threshold, used by gap holdoff
	wire inactive = self_src ? (slope_neg ? above_q : ~above_q) :
		(src == SRC_EXT) ? (slope_neg ? ext_q : ~ext_q) : 1'b1;
	wire valid_edge = raw_edge & armed_q & (mode != TM_FREE);
	wire auto_mode = mode == TM_AUTO || mode == TM_AUTOLVL;
	wire to_hit = auto_mode && to_cnt_q >= ato_q;

	// previous levels for edge detection
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			above_q <= 1'b0;
			ext_q <= 1'b0;
		end
		else
		begin
			if (sample_valid)
				above_q <= above_now;
			ext_q <= ext_trig_in;
		end
	end

	// peak tracking; midpoint of a window's peak-to-peak becomes the threshold
	wire signed [16:0] pk_sum = 17'(pk_max_q) + 17'(pk_min_q);
	always_ff @(posedge core_clk)
	begin
		if (set_rst)
		begin
			pk_max_q <= 16'sh8000;
			pk_min_q <= 16'sh7fff;
			al_thr_q <= `ATC_LVL_RST;
			win_q <= 8'h00;
		end
		else if (sample_valid)
		begin
			win_q <= win_q + 8'h01;
			if (win_q == `ATC_AL_WIN)
			begin
				al_thr_q <= pk_sum[16:1];
				pk_max_q <= sample_level;
				pk_min_q <= sample_level;
			end
			else
			begin
				if (sample_level > pk_max_q)
					pk_max_q <= sample_level;
				if (sample_level < pk_min_q)
					pk_min_q <= sample_level;
			end
		end
	end

	// holdoff: normal counts after an edge, gap counts time spent inactive
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			armed_q <= 1'b1;
			ho_cnt_q <= 32'h00000000;
		end
		else if (valid_edge)
		begin
			armed_q <= 1'b0;
			ho_cnt_q <= 32'h00000000;
		end
		else if (gap_mode)
		begin
			if (!inactive && !armed_q)
				ho_cnt_q <= 32'h00000000;
			else if (ho_cnt_q < hold_q)
				ho_cnt_q <= ho_cnt_q + 32'h00000001;
			else
				armed_q <= 1'b1;
		end
		else if (!armed_q)
		begin
			if (ho_cnt_q < hold_q)
				ho_cnt_q <= ho_cnt_q + 32'h00000001;
			else
				armed_q <= 1'b1;
		end
	end

	// auto timeout, restarted by every real edge so real triggers take over
	always_ff @(posedge core_clk)
	begin
		if (sys_rst || valid_edge || to_hit)
			to_cnt_q <= 32'h00000000;
		else
			to_cnt_q <= to_cnt_q + 32'h00000001;
	end

	// ------------------------------------------------------------
	// acquisition sequencer
	// ------------------------------------------------------------
	atc_state_t st_q;
	atc_state_t st_d;
	logic cont_q;
	logic start_q;
	logic clr_q;
	logic tout_q;
	logic [31:0] cnt_q;

	wire fire = (mode == TM_FREE) | valid_edge | to_hit;

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:
			begin
				if (c_run | c_single)
					st_d = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (c_halt)
					st_d = ST_IDLE;
				else if (fire)
					st_d = ST_CAPT;
			end
			ST_CAPT:
			begin
				if (c_halt)
					st_d = ST_IDLE;
				else if (acq_done)
					st_d = cont_q ? ST_WAIT : ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			st_q <= ST_IDLE;
			cont_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			if (c_run)
				cont_q <= 1'b1;
			else if (c_single | c_halt)
				cont_q <= 1'b0;
		end
	end

	// output pulses and completed-acquisition count; clear zeroes the count
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			start_q <= 1'b0;
			clr_q <= 1'b0;
			tout_q <= 1'b0;
			cnt_q <= 32'h00000000;
		end
		else
		begin
			start_q <= st_q == ST_WAIT && st_d == ST_CAPT;
			clr_q <= c_clear;
			tout_q <= valid_edge & self_src;
			if (c_clear)
				cnt_q <= 32'h00000000;
			else if (st_q == ST_CAPT && acq_done && !c_halt)
				cnt_q <= cnt_q + 32'h00000001;
		end
	end

	// registered settings toward the capture engine
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			rate_shift <= 4'h0;
		else
			rate_shift <= shift_c;
	end

	assign acq_start = start_q;
	assign acq_active = st_q != ST_IDLE;
	assign trace_clear = clr_q;
	assign trig_out = tout_q;
	assign slave_mode = slave;
	assign timebase_idx = tb_q;
	assign trig_delay_ns = dly_q;
	assign trig_pos_div = pos_q;

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	wire [15:0] lvl_show = 16'(lvl_q + ofs_q);
	wire [31:0] stat_w = {20'h00000, rate_shift, armed_q, slave, cont_q, 2'b00, st_q};
	always_comb
	begin
		if (avs_address == `ATC_REG_STAT)
			rd_mux = stat_w;
		else if (avs_address == `ATC_REG_TB)
			rd_mux = {27'h0000000, tb_q};
		else if (avs_address == `ATC_REG_DLY)
			rd_mux = dly_q;
		else if (avs_address == `ATC_REG_POS)
			rd_mux = {{24{pos_q[7]}}, pos_q};
		else if (avs_address == `ATC_REG_TCTL)
			rd_mux = {23'h000000, tctl_q};
		else if (avs_address == `ATC_REG_LVL)
			rd_mux = {{16{lvl_show[15]}}, lvl_show};
		else if (avs_address == `ATC_REG_OFS)
			rd_mux = {{16{ofs_q[15]}}, ofs_q};
		else if (avs_address == `ATC_REG_HOLD)
			rd_mux = hold_q;
		else if (avs_address == `ATC_REG_ATO)
			rd_mux = ato_q;
		else if (avs_address == `ATC_REG_CNT)
			rd_mux = cnt_q;
		else
			rd_mux = 32'h00000000; // command and unmapped read as zero
	end

endmodule

// File: rtl/atc_params.svh
// constants of the acquisition and trigger controller
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH

// register byte offsets
`define ATC_REG_CMD 6'h00
`define ATC_REG_STAT 6'h04
`define ATC_REG_TB 6'h08
`define ATC_REG_DLY 6'h0c
`define ATC_REG_POS 6'h10
`define ATC_REG_TCTL 6'h14
`define ATC_REG_LVL 6'h18
`define ATC_REG_OFS 6'h1c
`define ATC_REG_HOLD 6'h20
`define ATC_REG_ATO 6'h24
`define ATC_REG_CNT 6'h28
// command bits
`define ATC_CMD_RUN 0
`define ATC_CMD_HALT 1
`define ATC_CMD_SINGLE 2
`define ATC_CMD_CLEAR 3
`define ATC_CMD_DFLT 4
`define ATC_CMD_ZERO 5
`define ATC_CMD_POSL 6
`define ATC_CMD_POSM 7
`define ATC_CMD_POSR 8
// trigger control field positions
`define ATC_TC_MODE 0
`define ATC_TC_SLOPE 2
`define ATC_TC_HMODE 3
`define ATC_TC_SRC 4
`define ATC_TC_CHSEL 6
// reset values
`define ATC_TB_RST 5'h0a
`define ATC_POS_RST 8'h00
`define ATC_LVL_RST 16'h0000
`define ATC_TCTL_RST 9'h000
`define ATC_HOLD_RST 32'h00000000
// limits: level in 0.1 dB, delay in ns
`define ATC_TB_MAX 5'h15
`define ATC_POS_MIN (-8'sd30)
`define ATC_POS_MAX 8'sd30
`define ATC_POS_MID 8'sd5
`define ATC_POS_RIGHT 8'sd10
`define ATC_LVL_MAX 16'sd200
`define ATC_LVL_MIN_DEF 16'sh fda8
`define ATC_PRE_MAX_NS 40'sd1260000
// auto timeout figure and auto level window
`define ATC_CLK_MHZ 25
`define ATC_ATO_MS 100
`define ATC_ATO_CYC (`ATC_ATO_MS * 1000 * `ATC_CLK_MHZ)
`define ATC_AL_WIN 8'hff
// delay range per timebase row, ns
`define ATC_DMIN0 32'd1260000
`define ATC_DMIN2 32'd5040000
`define ATC_DMIN3 32'd6300000
`define ATC_DMIN4 32'd12600000
`define ATC_DMIN5 32'd31500000
`define ATC_DMIN6 32'd63000000
`define ATC_DMIN7 32'd126000000
`define ATC_DMIN8 32'd252000000
`define ATC_DMIN9 32'd628000000
`define ATC_DMAX0 32'd100000000
`define ATC_DMAX1 32'd200000000
`define ATC_DMAX3 32'd500000000
`define ATC_DMAX4 32'd1000000000
`endif

// File: rtl/atc_pkg.sv
// types of the acquisition and trigger controller
package atc_pkg;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_CAPT = 3'b100
	} atc_state_t;
	typedef enum logic [1:0]
	{
		TM_NORMAL = 2'h0,
		TM_AUTO = 2'h1,
		TM_AUTOLVL = 2'h2,
		TM_FREE = 2'h3
	} atc_mode_t;
	typedef enum logic [1:0]
	{
		SRC_OWN = 2'h0,
		SRC_CHAN = 2'h1,
		SRC_EXT = 2'h2
	} atc_src_t;
endpackage

// File: verification/atc_cap_model.sv
// capture engine and signal source beside the controller
`timescale 1ns/1ps
module atc_cap_model
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// capture handshake
	input wire logic acq_start,
	output logic acq_done,
	// signal source
	input wire logic signed [15:0] lvl_tgt,
	output logic sample_valid,
	output logic signed [15:0] sample_level
);
	logic [3:0] cnt_q;
	logic ph_q;
	// a capture lasts six cycles, then done pulses once
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cnt_q <= 4'h0;
			acq_done <= 1'b0;
			ph_q <= 1'b0;
		end
		else
		begin
			cnt_q <= acq_start ? 4'h6 : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
			acq_done <= cnt_q == 4'h1;
			ph_q <= ~ph_q;
		end
	end
	// between samples the level shows the inverse, so unqualified reads mislead
	assign sample_valid = ph_q;
	assign sample_level = ph_q ? lvl_tgt : ~lvl_tgt;
endmodule

// File: verification/atc_ctrl_props.sv
// assertions on the acquisition and trigger controller ports
`timescale 1ns/1ps
module atc_ctrl_props
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// register bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// capture control
	input wire logic acq_start,
	input wire logic acq_active,
	input wire logic trace_clear,
	input wire logic [4:0] timebase_idx,
	input wire logic signed [31:0] trig_delay_ns,
	input wire logic signed [7:0] trig_pos_div,
	input wire logic [3:0] rate_shift
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	// ----
	// bus handshake
	// ----
	sequence req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence req_done;
		!avs_waitrequest;
	endsequence
	bus_one_wait_a: assert property (req_wait |=> req_done)
		else $error("bus access took more than one wait cycle");
	bus_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high with no request");
	// ----
	// sequencing and settings
	// ----
	start_pulse_a: assert property (acq_start |=> !acq_start)
		else $error("start pulse longer than one cycle");
	start_armed_a: assert property (acq_start |-> acq_active && $past(acq_active))
		else $error("capture started from idle");
	clear_pulse_a: assert property (trace_clear |=> !trace_clear)
		else $error("clear pulse longer than one cycle");
	tb_step_a: assert property (timebase_idx <= 5'h15)
		else $error("timebase index beyond slowest step");
	pos_range_a: assert property (trig_pos_div >= -8'sd30 && trig_pos_div <= 8'sd30)
		else $error("trigger position outside range");
	dly_range_a: assert property (trig_delay_ns >= -32'sd628000000 &&
		trig_delay_ns <= 32'sd1000000000)
		else $error("trigger delay outside widest range");
	rate_idle_a: assert property ((trig_pos_div <= 0 && trig_delay_ns >= 0) [*3]
		|-> rate_shift == 4'h0)
		else $error("rate lowered with no pre-trigger span");
	rst_dflt_a: assert property ($fell(sys_rst) |-> timebase_idx == 5'h0a &&
		trig_delay_ns == 0 && trig_pos_div == 0 && rate_shift == 4'h0 && !acq_active)
		else $error("settings not at default after reset");
endmodule

// File: verification/atc_ctrl_tb.sv
// self-checking bench for the acquisition and trigger controller
`timescale 1ns/1ps
`include "atc_params.svh"
module atc_ctrl_tb;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sample_valid, ext_trig_in = 1'b0, acq_done;
	logic signed [15:0] sample_level;
	logic signed [15:0] lvl_tgt = -16'sd100;
	logic [7:0] chan_trig_in = 8'h00;
	logic [2:0] own_chan = 3'h0;
	logic acq_start, acq_active, trace_clear, trig_out, slave_mode;
	logic [4:0] timebase_idx;
	logic signed [31:0] trig_delay_ns;
	logic signed [7:0] trig_pos_div;
	logic [3:0] rate_shift;
	int fail_count = 0, check_count = 0, n_start = 0, n_clr = 0, cycles = 0, k;
	int n_trig = 0, m;
	always #20 core_clk = ~core_clk;
	// short auto timeout keeps the run brief
	atc_ctrl #(.AUTO_TMO_RST(32'h32)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
		.sample_level(sample_level), .ext_trig_in(ext_trig_in), .chan_trig_in(chan_trig_in),
		.own_chan(own_chan), .acq_done(acq_done), .acq_start(acq_start),
		.acq_active(acq_active), .trace_clear(trace_clear), .trig_out(trig_out),
		.slave_mode(slave_mode), .timebase_idx(timebase_idx), .trig_delay_ns(trig_delay_ns),
		.trig_pos_div(trig_pos_div), .rate_shift(rate_shift));
	atc_cap_model u_cap (.core_clk(core_clk), .sys_rst(sys_rst), .acq_start(acq_start),
		.acq_done(acq_done), .lvl_tgt(lvl_tgt), .sample_valid(sample_valid),
		.sample_level(sample_level));
	// ----
	// common tasks
	// ----
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// request held until waitrequest is sampled low at a rising edge; data taken there
	task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= we;
		avs_read <= !we;
		do
			@(posedge core_clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic chk_rd(input string nm, input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(nm, q, exp);
	endtask
	task automatic cmd(input int b);
		wr(`ATC_REG_CMD, 32'h1 << b);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// pulse counters and hang guard
	always @(posedge core_clk)
	begin
		n_start <= n_start + (acq_start === 1'b1);
		n_clr <= n_clr + (trace_clear === 1'b1);
		n_trig <= n_trig + (trig_out === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fail_count++;
			results();
		end
	end
	// ----
	// scenarios
	// ----
	task automatic t_reset;
		chk_rd("tb", `ATC_REG_TB, 32'h0000000a);
		chk_rd("dly", `ATC_REG_DLY, 32'h0);
		check("active", acq_active, 32'h0);
		chk_rd("unmapped", 6'h3c, 32'h0);
		chk_rd("cmd", `ATC_REG_CMD, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_single;
		wr(`ATC_REG_TCTL, 32'h3);
		k = n_start;
		cmd(`ATC_CMD_SINGLE);
		cyc(30);
		check("single starts", n_start - k, 32'h1);
		check("single idle", acq_active, 32'h0);
		chk_rd("count", `ATC_REG_CNT, 32'h1);
		$display("test single done");
	endtask
	task automatic t_run;
		k = n_start;
		cmd(`ATC_CMD_RUN);
		cyc(60);
		check("run repeats", n_start - k >= 3, 32'h1);
		cmd(`ATC_CMD_HALT);
		cyc(2);
		k = n_start;
		cyc(40);
		check("halt starts", n_start - k, 32'h0);
		check("halt idle", acq_active, 32'h0);
		$display("test run done");
	endtask
	task automatic t_clear;
		k = n_clr;
		cmd(`ATC_CMD_CLEAR);
		cyc(3);
		check("clear pulse", n_clr - k, 32'h1);
		chk_rd("count", `ATC_REG_CNT, 32'h0);
		$display("test clear done");
	endtask
	task automatic t_time;
		wr(`ATC_REG_TB, 32'h1f);
		cyc(1);
		check("tb clamp", timebase_idx, 32'h15);
		wr(`ATC_REG_TB, 32'h0a);
		wr(`ATC_REG_DLY, 32'h0bebc200);
		cyc(2);
		check("dly max", trig_delay_ns, 32'h05f5e100);
		wr(`ATC_REG_POS, 32'h0a);
		cyc(3);
		check("rate post", rate_shift, 32'h0);
		wr(`ATC_REG_DLY, 32'hffe17b80);
		cyc(3);
		check("dly min", trig_delay_ns, 32'hffecc620);
		check("rate pre", rate_shift, 32'h1);
		cmd(`ATC_CMD_ZERO);
		cyc(2);
		check("dly zero", trig_delay_ns, 32'h0);
		wr(`ATC_REG_POS, 32'h28);
		cyc(1);
		check("pos max", 32'(trig_pos_div), 32'h1e);
		wr(`ATC_REG_POS, 32'hffffffd8);
		cyc(1);
		check("pos min", 32'(trig_pos_div), 32'hffffffe2);
		for (int i = 0; i < 3; i++)
		begin
			cmd(`ATC_CMD_POSL + i);
			cyc(2);
			check("pos preset", 32'(trig_pos_div), i * 5);
		end
		wr(`ATC_REG_TB, 32'h03);
		wr(`ATC_REG_DLY, 32'h3e8);
		cmd(`ATC_CMD_DFLT);
		cyc(2);
		check("dflt tb", timebase_idx, 32'h0a);
		check("dflt pos", 32'(trig_pos_div), 32'h0);
		check("dflt dly", trig_delay_ns, 32'h0);
		chk_rd("dflt tctl", `ATC_REG_TCTL, 32'h0);
		$display("test timebase done");
	endtask
	task automatic t_level;
		wr(`ATC_REG_LVL, 32'h12c);
		chk_rd("lvl max", `ATC_REG_LVL, 32'hc8);
		wr(`ATC_REG_OFS, 32'hc8);
		chk_rd("lvl shifted", `ATC_REG_LVL, 32'h190);
		wr(`ATC_REG_LVL, 32'h1f4);
		chk_rd("lvl new max", `ATC_REG_LVL, 32'h190);
		wr(`ATC_REG_LVL, 32'h15e);
		chk_rd("lvl inside", `ATC_REG_LVL, 32'h15e);
		wr(`ATC_REG_OFS, 32'h0);
		wr(`ATC_REG_LVL, 32'h0);
		$display("test level done");
	endtask
	// both slopes: no sweep while on the inactive side, one on the crossing
	task automatic t_norm;
		for (int s = 0; s < 2; s++)
		begin
			lvl_tgt <= s ? 16'sd100 : -16'sd100;
			wr(`ATC_REG_TCTL, s << 2);
			k = n_start;
			cmd(`ATC_CMD_SINGLE);
			cyc(60);
			check("no self sweep", n_start - k, 32'h0);
			lvl_tgt <= s ? -16'sd100 : 16'sd100;
			cyc(30);
			check("slope edge", n_start - k, 32'h1);
		end
		$display("test normal done");
	endtask
	// a crossing inside the holdoff time, or after too short a gap, must not fire
	task automatic t_hold;
		wr(`ATC_REG_TCTL, 32'h0);
		wr(`ATC_REG_HOLD, 32'hc8);
		k = n_start;
		m = n_trig;
		cmd(`ATC_CMD_RUN);
		lvl_tgt <= 16'sd100;
		cyc(30);
		lvl_tgt <= -16'sd100;
		cyc(10);
		lvl_tgt <= 16'sd100;
		cyc(30);
		check("holdoff", n_start - k, 32'h1);
		check("trig out", n_trig - m, 32'h1);
		wr(`ATC_REG_TCTL, 32'h8);
		lvl_tgt <= -16'sd100;
		cyc(100);
		lvl_tgt <= 16'sd100;
		cyc(30);
		check("short gap", n_start - k, 32'h1);
		lvl_tgt <= -16'sd100;
		cyc(250);
		lvl_tgt <= 16'sd100;
		cyc(30);
		check("long gap", n_start - k, 32'h2);
		cmd(`ATC_CMD_HALT);
		wr(`ATC_REG_HOLD, 32'h0);
		$display("test holdoff done");
	endtask
	task automatic t_auto;
		lvl_tgt <= -16'sd100;
		wr(`ATC_REG_ATO, 32'h28);
		wr(`ATC_REG_TCTL, 32'h1);
		k = n_start;
		cmd(`ATC_CMD_SINGLE);
		cyc(120);
		check("auto sweep", n_start - k, 32'h1);
		$display("test auto done");
	endtask
	task automatic t_src;
		wr(`ATC_REG_TCTL, 32'h20);
		k = n_start;
		cmd(`ATC_CMD_SINGLE);
		cyc(30);
		check("ext quiet", n_start - k, 32'h0);
		ext_trig_in <= 1'b1;
		cyc(20);
		check("ext edge", n_start - k, 32'h1);
		ext_trig_in <= 1'b0;
		own_chan <= 3'h1;
		wr(`ATC_REG_TCTL, 32'hd0);
		cyc(2);
		check("slave on", slave_mode, 32'h1);
		k = n_start;
		cmd(`ATC_CMD_SINGLE);
		cyc(10);
		chan_trig_in <= 8'h08;
		cyc(1);
		chan_trig_in <= 8'h00;
		cyc(20);
		check("slave fire", n_start - k, 32'h1);
		wr(`ATC_REG_TCTL, 32'h50);
		cyc(2);
		check("master", slave_mode, 32'h0);
		$display("test source done");
	endtask
	initial
	begin
		cyc(6);
		sys_rst <= 1'b0;
		t_reset();
		t_single();
		t_run();
		t_clear();
		t_time();
		t_level();
		t_norm();
		t_hold();
		t_auto();
		t_src();
		results();
	end
endmodule
bind atc_ctrl atc_ctrl_props u_props (.core_clk(core_clk), .sys_rst(sys_rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.acq_start(acq_start), .acq_active(acq_active), .trace_clear(trace_clear),
	.timebase_idx(timebase_idx), .trig_delay_ns(trig_delay_ns),
	.trig_pos_div(trig_pos_div), .rate_shift(rate_shift));
